// [flh_fault_latch.sv]
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flh_fault_latch #(
    parameter logic [31:0] MAINS_DELAY_CYC = 32'(flh_pkg::MAINS_DELAY_S * flh_pkg::CLK_HZ)
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [flh_pkg::ADDR_W-1:0] paddr,
    input  wire logic [flh_pkg::DATA_W-1:0] pwdata,
    output var  logic [flh_pkg::DATA_W-1:0] prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire flh_pkg::flh_fault_s        faults,
    input  wire logic                       supply_dip,
    input  wire logic                       stop_key,
    input  wire logic                       reset_input,
    input  wire logic                       keypad_attached,
    input  wire flh_pkg::flh_snap_s         snap,
    output var  logic                       power_inhibit,
    output var  logic                       alarm_led,
    output var  logic                       brake_off,
    output var  logic                       show_code,
    output var  logic [7:0]                 error_code
);

    flh_pkg::flh_state_e state;
    flh_pkg::flh_state_e next_state;
    flh_pkg::flh_hist_s  hist [flh_pkg::DEPTH];
    logic [15:0]         fault_count;
    logic [7:0]          history_clear_setting;
    logic [31:0]         uptime;
    logic                powerup_seen;

    logic        restart_hit;
    logic        mains_hit;
    logic [7:0]  oc_code;
    logic [7:0]  new_code;
    logic        any_fault;
    logic        new_fault;
    logic        ack;
    logic        wr_en;
    logic        rd_setup;
    logic        clr_wr;
    logic        hist_hit;
    logic [1:0]  slot_idx;
    logic [1:0]  word_idx;
    flh_pkg::flh_hist_s sel_entry;
    logic [31:0] hist_word;
    logic        addr_hit;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    // Restart guard is judged on the first cycle after release or on a dip
    assign restart_hit = faults.unattended_start_guard && (!powerup_seen || supply_dip);
    // Mains overvoltage only trips once the supply has been on long enough
    assign mains_hit   = faults.mains_high && (uptime >= MAINS_DELAY_CYC);

    // Overcurrent number depends on the operating phase
    assign oc_code = (faults.phase == flh_pkg::PH_DECEL) ? flh_pkg::E_OC_DEC  :
                     (faults.phase == flh_pkg::PH_ACCEL) ? flh_pkg::E_OC_ACC  :
                     (faults.phase == flh_pkg::PH_STOP)  ? flh_pkg::E_OC_STOP :
                                                           flh_pkg::E_OC_RUN;

    // Fixed priority picks one code when several faults arrive together
    assign new_code = faults.overcurrent          ? oc_code              :
                      faults.overload             ? flh_pkg::E_OVLD      :
                      faults.brake_duty_high      ? flh_pkg::E_BRAKE     :
                      faults.regen_overvolt       ? flh_pkg::E_REGEN     :
                      faults.memory_fault         ? flh_pkg::E_MEM       :
                      faults.undervolt            ? flh_pkg::E_UNDER     :
                      faults.cpu_fault            ? flh_pkg::E_CPU       :
                      faults.external_fault_input ? flh_pkg::E_EXT       :
                      restart_hit                 ? flh_pkg::E_RESTART   :
                      faults.ground_fault         ? flh_pkg::E_GROUND    :
                      mains_hit                   ? flh_pkg::E_MAINS     :
                      faults.overtemp             ? flh_pkg::E_TEMP      :
                      faults.gate_link_fault      ? flh_pkg::E_LINK      :
                      faults.thermistor_input     ? flh_pkg::E_THERM     :
                      faults.comm_timeout         ? flh_pkg::E_COMM      :
                                                    flh_pkg::E_NONE;

    assign any_fault = (new_code != flh_pkg::E_NONE);
    // Only the first fault of a latched episode is taken
    assign new_fault = any_fault && (state == flh_pkg::FS_CLEAR);
    assign ack       = stop_key || reset_input;

    // Latch state; a fault still present after acknowledge relatches next cycle
    always_comb
    begin
        next_state = state;
        unique case (state)
            flh_pkg::FS_CLEAR:   if (any_fault) next_state = flh_pkg::FS_LATCHED;
            flh_pkg::FS_LATCHED: if (ack) next_state = flh_pkg::FS_CLEAR;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            state <= flh_pkg::FS_CLEAR;
        else
            state <= next_state;
    end

    // Inhibit, alarm and keypad code follow the latch state
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            power_inhibit <= 1'b0;
            alarm_led     <= 1'b0;
            show_code     <= 1'b0;
        end
        else
        begin
            power_inhibit <= (next_state == flh_pkg::FS_LATCHED);
            alarm_led     <= (next_state == flh_pkg::FS_LATCHED);
            show_code     <= (next_state == flh_pkg::FS_LATCHED) && keypad_attached;
        end
    end

    // Latched number; reads as none once acknowledged
    always_ff @(posedge clk)
    begin
        if (!resetn)
            error_code <= flh_pkg::E_NONE;
        else if (new_fault)
            error_code <= new_code;
        else if (state == flh_pkg::FS_LATCHED && ack)
            error_code <= flh_pkg::E_NONE;
    end

    // Brake switch stays off until acknowledge; a new trip wins over the clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
            brake_off <= 1'b0;
        else if (faults.brake_duty_high)
            brake_off <= 1'b1;
        else if (ack)
            brake_off <= 1'b0;
    end

    // Power-up marker and saturating on-time counter
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            powerup_seen <= 1'b0;
            uptime       <= '0;
        end
        else
        begin
            powerup_seen <= 1'b1;
            if (uptime != MAINS_DELAY_CYC)
                uptime <= uptime + 32'h1;
        end
    end

    // Bus decode; slave answers one cycle after setup with no further wait
    assign wr_en    = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;
    assign clr_wr   = wr_en && (paddr == flh_pkg::OFS_CLEAR) &&
                      (pwdata[7:0] == flh_pkg::CLR_ALL || pwdata[7:0] == flh_pkg::CLR_ALT);
    assign hist_hit = (paddr >= flh_pkg::OFS_HIST_BASE) && (paddr <= flh_pkg::OFS_HIST_LAST) &&
                      (paddr[1:0] == 2'b00);
    assign slot_idx = paddr[5:4] - 2'b01;
    assign word_idx = paddr[3:2];

    // Entry readout: four words per slot, newest first
    assign sel_entry = (slot_idx == 2'b10) ? hist[2] :
                       (slot_idx == 2'b01) ? hist[1] : hist[0];
    assign hist_word = (word_idx == 2'b00) ? {8'h00, sel_entry.code, sel_entry.count} :
                       (word_idx == 2'b01) ? {sel_entry.snap.out_current, sel_entry.snap.out_freq} :
                       (word_idx == 2'b10) ? {16'h0000, sel_entry.snap.dc_link} :
                                             {sel_entry.snap.on_hours, sel_entry.snap.run_hours};

    assign status_word = {16'h0000, error_code, 6'h00, brake_off, state == flh_pkg::FS_LATCHED};
    assign addr_hit = (paddr == flh_pkg::OFS_STATUS) || (paddr == flh_pkg::OFS_CLEAR) ||
                      (paddr == flh_pkg::OFS_COUNT) || hist_hit;
    assign rd_word  = (paddr == flh_pkg::OFS_STATUS) ? status_word :
                      (paddr == flh_pkg::OFS_CLEAR)  ? {24'h000000, history_clear_setting} :
                      (paddr == flh_pkg::OFS_COUNT)  ? {16'h0000, fault_count} :
                      hist_hit                       ? hist_word : 32'h00000000;

    // Answer is prepared in the setup cycle so every bus output is a flop
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= rd_setup;
            pslverr <= rd_setup && (!addr_hit || (pwrite && paddr != flh_pkg::OFS_CLEAR));
            prdata  <= (rd_setup && !pwrite) ? rd_word : 32'h00000000;
        end
    end

    // Clear setting is stored whatever its value; only 00 and 02 clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
            history_clear_setting <= flh_pkg::CLR_RESET;
        else if (wr_en && paddr == flh_pkg::OFS_CLEAR)
            history_clear_setting <= pwdata[7:0];
    end

    // History shift; a fault in the clearing cycle still lands in the newest slot
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            fault_count <= '0;
            for (int i = 0; i < flh_pkg::DEPTH; i++)
                hist[i] <= '0;
        end
        else if (new_fault)
        begin
            fault_count <= clr_wr ? 16'h0001 : fault_count + 16'h0001;
            hist[0]     <= '{count: (clr_wr ? 16'h0001 : fault_count + 16'h0001),
                             code: new_code, snap: snap};
            for (int i = 1; i < flh_pkg::DEPTH; i++)
                hist[i] <= clr_wr ? '0 : hist[i-1];
        end
        else if (clr_wr)
        begin
            fault_count <= '0;
            for (int i = 0; i < flh_pkg::DEPTH; i++)
                hist[i] <= '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_fault_taken;
        new_fault ##1 (power_inhibit && alarm_led);
    endsequence

    // One latched cycle with no acknowledge in it
    sequence s_held_latched;
        power_inhibit && !ack;
    endsequence

    a_inhibit_on_fault: assert property (new_fault |-> s_fault_taken)
        else $error("Output not inhibited after fault");
    a_alarm_with_latch: assert property (power_inhibit |-> alarm_led && error_code != flh_pkg::E_NONE)
        else $error("Alarm or code missing while inhibited");
    a_keypad_code_shown: assert property (new_fault && keypad_attached |=> show_code && error_code == $past(new_code))
        else $error("Keypad code not shown");
    a_inhibit_held: assert property (s_held_latched |=> power_inhibit)
        else $error("Inhibit released without acknowledge");
    a_ack_releases: assert property (power_inhibit && ack && !any_fault |=> !power_inhibit && !alarm_led)
        else $error("Acknowledge did not release output");
    a_decel_overcur: assert property (new_fault && faults.overcurrent && faults.phase == flh_pkg::PH_DECEL
                                      |=> error_code == flh_pkg::E_OC_DEC)
        else $error("Wrong code for overcurrent while decelerating");
    a_brake_switch_off: assert property (faults.brake_duty_high |=> brake_off)
        else $error("Braking transistor left on");
    a_mains_wait: assert property (uptime < MAINS_DELAY_CYC && new_fault |=> error_code != flh_pkg::E_MAINS)
        else $error("Mains fault taken before delay");
    a_history_shift: assert property (new_fault && !clr_wr |=> hist[1] == $past(hist[0]) && hist[2] == $past(hist[1]))
        else $error("History did not shift");
    a_history_keep: assert property (!new_fault && !clr_wr |=> hist[0] == $past(hist[0]))
        else $error("History changed without fault or clear");
    a_history_clear: assert property (clr_wr && !new_fault |=> hist[0].count == 16'h0000 && fault_count == 16'h0000)
        else $error("History not cleared");

endmodule // flh_fault_latch
`default_nettype wire

// [flh_pkg.sv]
// How it works
// - Any fault inhibits the power output at once
// - Latched fault drives the red alarm indicator
// - Keypad shows E plus latched fault number
// - Inhibit holds until stop, reset input, power-off
// - Overcurrent code follows phase: 01,02,03,04
// - Braking duty too high: brake off, E06
// - Regenerative overvoltage reports E07
// - Unreliable nonvolatile memory reports E08
// - Low DC link voltage reports E09
// - Processor malfunction reports E11
// - External fault input latches E12
// - Power-up or dip with guard: E13
// - Ground fault on any output: E14
// - Mains too high: E15 after 100 s
// - Power section overtemperature reports E21
// - Processor to logic link failure: E23
// - Thermistor resistance too high reports E35
// - Serial communication timeout reports E60
// - History keeps three newest faults readable
// - New fault enters newest slot, others shift
// - Entry holds count, code, frequency, current, DC link voltage, hours
// - History setting written 00 or 02 clears
`default_nettype none
package flh_pkg;

    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned DEPTH   = 3;

    // Register byte addresses
    localparam logic [7:0] OFS_STATUS    = 8'h00;
    localparam logic [7:0] OFS_CLEAR     = 8'h04;
    localparam logic [7:0] OFS_COUNT     = 8'h08;
    localparam logic [7:0] OFS_HIST_BASE = 8'h10;
    localparam logic [7:0] OFS_HIST_LAST = 8'h3c;

    // Status field positions
    localparam int unsigned ST_LATCH_BIT = 0;
    localparam int unsigned ST_BRAKE_BIT = 1;
    localparam int unsigned ST_CODE_LSB  = 8;

    // History clear setting values
    localparam logic [7:0] CLR_ALL   = 8'h00;
    localparam logic [7:0] CLR_ALT   = 8'h02;
    localparam logic [7:0] CLR_RESET = 8'h01;

    // Fault numbers, two decimal digits as shown after the letter E
    localparam logic [7:0] E_NONE = 8'h00;
    localparam logic [7:0] E_OC_RUN = 8'h01, E_OC_DEC = 8'h02, E_OC_ACC = 8'h03, E_OC_STOP = 8'h04;
    localparam logic [7:0] E_OVLD = 8'h05, E_BRAKE = 8'h06, E_REGEN = 8'h07, E_MEM = 8'h08;
    localparam logic [7:0] E_UNDER = 8'h09, E_CPU = 8'h11, E_EXT = 8'h12, E_RESTART = 8'h13;
    localparam logic [7:0] E_GROUND = 8'h14, E_MAINS = 8'h15, E_TEMP = 8'h21, E_LINK = 8'h23;
    localparam logic [7:0] E_THERM = 8'h35, E_COMM = 8'h60;

    // Mains overvoltage shutdown delay
    localparam longint unsigned MAINS_DELAY_S = 100;
    localparam longint unsigned CLK_HZ        = 40_000_000;

    typedef enum logic [1:0] {PH_RUN = 2'b00, PH_DECEL = 2'b01, PH_ACCEL = 2'b10, PH_STOP = 2'b11} flh_phase_e;
    typedef enum logic {FS_CLEAR = 1'b0, FS_LATCHED = 1'b1} flh_state_e;

    typedef struct packed {
        logic       overcurrent;
        flh_phase_e phase;
        logic       overload;
        logic       brake_duty_high;
        logic       regen_overvolt;
        logic       memory_fault;
        logic       undervolt;
        logic       cpu_fault;
        logic       external_fault_input;
        logic       unattended_start_guard;
        logic       ground_fault;
        logic       mains_high;
        logic       overtemp;
        logic       gate_link_fault;
        logic       thermistor_input;
        logic       comm_timeout;
    } flh_fault_s;

    typedef struct packed {
        logic [15:0] out_freq;
        logic [15:0] out_current;
        logic [15:0] dc_link;
        logic [15:0] run_hours;
        logic [15:0] on_hours;
    } flh_snap_s;

    typedef struct packed {
        logic [15:0] count;
        logic [7:0]  code;
        flh_snap_s   snap;
    } flh_hist_s;

endpackage
`default_nettype wire

// [flh_panel.sv]
`timescale 1ns/1ps
`default_nettype none
// Keypad and control terminals as the fault latch sees them
module flh_panel (
    input  wire logic       clk,
    input  wire logic [1:0] ack_kind,
    input  wire logic       ext_on,
    input  wire logic       kp_on,
    output var  logic       stop_key,
    output var  logic       reset_input,
    output var  logic       ext_fault,
    output var  logic       keypad_attached
);
    // Terminals pass through an input register, so every request lands one edge late
    always_ff @(posedge clk)
    begin
        stop_key        <= (ack_kind == 2'd1);
        reset_input     <= (ack_kind == 2'd2);
        ext_fault       <= ext_on;
        keypad_attached <= kp_on;
    end
endmodule // flh_panel
`default_nettype wire

// [fault_latch_and_history_test.sv]
`timescale 1ns/1ps
`default_nettype none
module fault_latch_and_history_test;
    logic                clk, resetn, psel, penable, pwrite, pready, pslverr, er;
    logic                power_inhibit, alarm_led, brake_off, show_code, supply_dip;
    logic                stop_key, reset_input, ext_fault, keypad_attached, ext_on, kp_on;
    logic [1:0]          ack_kind;
    logic [7:0]          paddr, error_code;
    logic [31:0]         pwdata, prdata, rd;
    flh_pkg::flh_fault_s flt, fault_in;
    flh_pkg::flh_snap_s  snap;
    logic [7:0]          codes [18];
    logic [31:0]         m_w0 [$];
    flh_pkg::flh_snap_s  m_sn [$];
    int                  m_count, seed, err_total, checked;

    flh_fault_latch #(.MAINS_DELAY_CYC(32'd50)) i_flh_fault_latch (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .faults(fault_in), .supply_dip(supply_dip), .stop_key(stop_key), .reset_input(reset_input),
        .keypad_attached(keypad_attached), .snap(snap), .power_inhibit(power_inhibit),
        .alarm_led(alarm_led), .brake_off(brake_off), .show_code(show_code), .error_code(error_code));

    flh_panel i_flh_panel (
        .clk(clk), .ack_kind(ack_kind), .ext_on(ext_on), .kp_on(kp_on), .stop_key(stop_key),
        .reset_input(reset_input), .ext_fault(ext_fault), .keypad_attached(keypad_attached));

    // External fault reaches the block through the terminal model
    always_comb
    begin
        fault_in = flt;
        fault_in.external_fault_input = ext_fault;
    end

    // Free running clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic finish_test();
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer; it waits for pready as long as it takes, the watchdog ends a dead slave
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Single fault source by index; index 10 comes from the terminal model
    function automatic flh_pkg::flh_fault_s mk(input int i);
        logic [16:0] v;
        v = '0;
        if (i < 4)
            v = {1'b1, 2'(i), 14'h0};
        else if (i != 10)
            v[17-i] = 1'b1;
        return flh_pkg::flh_fault_s'(v);
    endfunction

    // All four words of every slot, against the model's snapshots
    task automatic chk_hist();
        flh_pkg::flh_snap_s p;
        for (int s = 0; s < 3; s++)
        begin
            p = (s < m_sn.size()) ? m_sn[s] : '0;
            apb(1'b0, 8'h10 + 8'(16 * s), 32'h0);
            chk("hist_head", (s < m_w0.size()) ? m_w0[s] : 32'h0, rd);
            apb(1'b0, 8'h14 + 8'(16 * s), 32'h0);
            chk("hist_snap", {p.out_current, p.out_freq}, rd);
            apb(1'b0, 8'h18 + 8'(16 * s), 32'h0);
            chk("hist_link", {16'h0000, p.dc_link}, rd);
            apb(1'b0, 8'h1c + 8'(16 * s), 32'h0);
            chk("hist_hours", {p.on_hours, p.run_hours}, rd);
        end
        apb(1'b0, flh_pkg::OFS_COUNT, 32'h0);
        chk("fault_count", 32'(m_count), rd);
    endtask

    // Raise a fault, pile a second one on while latched, acknowledge, then audit history
    task automatic hit(input flh_pkg::flh_fault_s f, input logic x, input logic [7:0] c, input logic kp);
        @(posedge clk);
        kp_on <= kp;
        flt <= f;
        ext_on <= x;
        supply_dip <= f.unattended_start_guard;
        snap <= 80'({$random(seed), $random(seed), $random(seed)});
        repeat (3) @(posedge clk);
        #1;
        m_count++;
        m_w0.push_front({8'h00, c, 16'(m_count)});
        m_sn.push_front(snap);
        if (m_w0.size() > 3)
        begin
            void'(m_w0.pop_back());
            void'(m_sn.pop_back());
        end
        chk("error_code", 32'(c), 32'(error_code));
        chk("inhibit_alarm", 32'h3, {power_inhibit, alarm_led});
        chk("show_code", 32'(kp), 32'(show_code));
        chk("brake_off", 32'(f.brake_duty_high), 32'(brake_off));
        @(posedge clk);
        flt <= flh_pkg::flh_fault_s'(f | mk(14));
        @(posedge clk);
        #1;
        chk("code_held", 32'(c), 32'(error_code));
        @(posedge clk);
        flt <= '0;
        ext_on <= 1'b0;
        supply_dip <= 1'b0;
        ack_kind <= 2'd1 + 2'(c[0]);
        @(posedge clk);
        ack_kind <= 2'd0;
        repeat (3) @(posedge clk);
        #1;
        chk("released", 32'h0, {power_inhibit, alarm_led, brake_off, error_code});
        chk_hist();
    endtask

    // Stall guard
    initial
    begin
        repeat (8000) @(posedge clk);
        err_total++;
        finish_test();
    end

    initial
    begin
        seed = 34295;
        {err_total, checked, m_count} = '0;
        {resetn, psel, penable, pwrite, ext_on, supply_dip} = '0;
        {paddr, pwdata, ack_kind, flt, snap} = '0;
        kp_on = 1'b1;
        codes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                  8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h21, 8'h23, 8'h35, 8'h60};
        repeat (5) @(posedge clk);
        #1;
        chk("reset_outputs", 32'h0, {power_inhibit, alarm_led, brake_off, show_code, error_code});
        @(posedge clk);
        resetn <= 1'b1;
        // Mains high before the delay has run: only the lower fault beside it may latch
        hit(flh_pkg::flh_fault_s'(mk(13) | mk(14)), 1'b0, 8'h21, 1'b1);
        apb(1'b0, flh_pkg::OFS_CLEAR, 32'h0);
        chk("clear_reset", 32'h1, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, 32'(er));
        apb(1'b1, flh_pkg::OFS_COUNT, $random(seed));
        chk("ro_err", 32'h1, 32'(er));
        for (int i = 0; i < 18; i++)
            hit(mk(i), i == 10, codes[i], i[0]);
        hit(flh_pkg::flh_fault_s'(mk(12) | mk(13)), 1'b0, 8'h14, 1'b1);
        // Settings 00 and 02 clear; 04 is stored but must leave the history alone
        for (int k = 0; k < 3; k++)
        begin
            apb(1'b1, flh_pkg::OFS_CLEAR, 32'(2 * k));
            if (k < 2)
            begin
                m_w0.delete();
                m_sn.delete();
                m_count = 0;
            end
            apb(1'b0, flh_pkg::OFS_CLEAR, 32'h0);
            chk("clear_rw", 32'(2 * k), rd);
            chk_hist();
            hit(mk(8), 1'b0, 8'h09, 1'b1);
        end
        // Second power-up with the start guard held: restart inhibit latches at once
        @(posedge clk);
        resetn <= 1'b0;
        flt <= mk(11);
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("powerup_guard", 32'h313, {power_inhibit, alarm_led, error_code});
        finish_test();
    end
endmodule // fault_latch_and_history_test
`default_nettype wire
